// >>> inc/isio_pkg.sv
/*
 Types shared by the instrument status I/O ports.
 Assumes isio_regs.svh is available on the include path.
*/
`include "isio_regs.svh"

package isio_pkg;
	// Register port access kind
	typedef enum logic [1:0] {ISIO_IDLE, ISIO_READ, ISIO_WRITE} isio_acc_type;
	typedef logic [`ISIO_DW-1:0] isio_byte_type;
	typedef logic [`ISIO_EV_W-1:0] isio_ev_type;
endpackage

// >>> inc/isio_regs.svh
/*
 Register offsets, field positions and reset values of the instrument status I/O ports.
 Assumes a 10-bit byte address on the register port and 8-bit data.
*/
`ifndef ISIO_REGS_SVH
`define ISIO_REGS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define ISIO_AW 10
`define ISIO_DW 8
`define ISIO_CAL_W 6
`define ISIO_EV_W 4

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ISIO_CAL_PORT 10'h321
`define ISIO_INT_PORT 10'h322
`define ISIO_STAT_PORT 10'h323
`define ISIO_ALARM_PORT 10'h325
`define ISIO_COIL_SEL 10'h330
`define ISIO_COIL_VAL 10'h331
`define ISIO_EV_STATUS 10'h340
`define ISIO_EV_CLEAR 10'h341
`define ISIO_EV_ENABLE 10'h342

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ISIO_ZERO_BIT 0
`define ISIO_LOW_SPAN_BIT 1
`define ISIO_SPAN_BIT 2
`define ISIO_PERIPH_RST_BIT 6
`define ISIO_DRV_RST_BIT 7
`define ISIO_HEALTH_BIT 4
`define ISIO_LIM1_BIT 5
`define ISIO_LIM2_BIT 6
`define ISIO_RANGE_BIT 7
`define ISIO_SYS_FLAG_BIT 0
`define ISIO_VALID_FLAG_BIT 1
`define ISIO_RANGE_FLAG_BIT 2
`define ISIO_EV_RELEASE_BIT 3

// ----------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------
`define ISIO_IN_IDLE 8'hff
`define ISIO_CAL_IDLE 6'h3f
`define ISIO_TOP_ONES 2'h3
`define ISIO_INT_OUT_RST 8'h80
`define ISIO_STAT_RST 8'h00
`define ISIO_ALARM_RST 8'h00
`define ISIO_SPARE_RST 8'h00
`define ISIO_ZERO_BYTE 8'h00
`define ISIO_ZERO_EV 4'h0

`endif

// >>> src/isio_sync.sv
/*
 Three-stage input synchroniser with agreement filter, one lane per bit.
 Assumes pins are asynchronous to mclk; idle level of every lane is one.
*/
`timescale 1ns/1ps
`include "isio_regs.svh"

module isio_sync #(
	parameter int WIDTH = 8
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_out
);
	// ----------------------------------------------------------------
	// Per-bit synchroniser chain
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_lane
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic lvl_q;
			// First stage feeds only the second
			always_ff @(posedge mclk or negedge nrst)
			begin
				if (!nrst)
				begin
					s1_q <= 1'b1;
					s2_q <= 1'b1;
					s3_q <= 1'b1;
				end
				else
				begin
					s1_q <= pin_in[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
				end
			end
			// Accept a new level once stages two and three agree
			always_ff @(posedge mclk or negedge nrst)
			begin
				if (!nrst)
					lvl_q <= 1'b1;
				else if (s2_q == s3_q)
					lvl_q <= s3_q;
			end
			assign level_out[i] = lvl_q;
		end
	endgenerate
endmodule

// >>> src/isio_top.sv
/*
 Instrument status I/O ports: calibration request inputs, internal I/O,
 status and alarm relay outputs, remote coil override and event interrupt.
 Assumes a single-cycle strobe register master on mclk and asynchronous pins.
*/
// The implementer's own choice: the address-and-strobe port.
// Operation
// RULE1: internal output bit 6 resets peripheral bus
// RULE2: cal bit 0 low requests zero calibration
// RULE3: cal bit 1 low requests low span
// RULE4: cal bit 2 low requests span calibration
// RULE5: equipment holds contacts low while wanted
// RULE6: cal request port at 321h, bits 0-5
// RULE7: health relay one only when healthy
// RULE8: alarm bit 5 shows limit one exceeded
// RULE9: alarm bit 6 shows limit two exceeded
// RULE10: alarm bit 7 mirrors upper range flag
// RULE11: each alarm bit overridable by remote coil
// RULE12: alarm bits 4-7 at port 325h
// RULE13: status bit 0 high on any alarm
// RULE14: status bit 1 zero while reading valid
// RULE15: status bit 2 zero in high range
// RULE16: status port eight bits at 323h
// RULE17: output ports hold last written value
// RULE18: input reads return synchronised pin levels
`timescale 1ns/1ps
`include "isio_regs.svh"

module isio_top (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [`ISIO_AW-1:0] reg_addr,
	input wire logic [`ISIO_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`ISIO_DW-1:0] reg_rdata,
	input wire logic [`ISIO_CAL_W-1:0] cal_request_n,
	input wire logic [`ISIO_CAL_W-1:0] spare_in_high,
	input wire logic [`ISIO_DW-1:0] internal_in,
	output logic [`ISIO_DW-1:0] spare_out_low,
	output logic [3:0] spare_out_high,
	output logic periph_bus_reset,
	output logic bus_driver_hw_reset_n,
	output logic system_health_flag,
	output logic reading_valid_flag,
	output logic upper_range_flag,
	output logic health_alarm_relay,
	output logic limit_one_alarm,
	output logic limit_two_alarm,
	output logic upper_range_relay,
	output logic irq
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [`ISIO_CAL_W-1:0] cal_lvl;
	logic [`ISIO_CAL_W-1:0] spare_lvl;
	logic [`ISIO_DW-1:0] int_lvl;
	logic [`ISIO_CAL_W-1:0] cal_prev_q;
	isio_pkg::isio_byte_type spare_low_q;
	isio_pkg::isio_byte_type int_out_q;
	isio_pkg::isio_byte_type stat_q;
	isio_pkg::isio_byte_type alarm_q;
	isio_pkg::isio_byte_type coil_sel_q;
	isio_pkg::isio_byte_type coil_val_q;
	isio_pkg::isio_ev_type ev_q;
	isio_pkg::isio_ev_type ev_en_q;
	isio_pkg::isio_ev_type ev_set;
	isio_pkg::isio_ev_type ev_clr;
	isio_pkg::isio_byte_type rdata_d;
	isio_pkg::isio_byte_type rdata_q;
	isio_pkg::isio_byte_type relay_d;
	isio_pkg::isio_byte_type relay_q;
	isio_pkg::isio_acc_type acc;
	logic wr_cal;
	logic wr_int;
	logic wr_stat;
	logic wr_alarm;
	logic wr_csel;
	logic wr_cval;
	logic wr_evclr;
	logic wr_even;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Calibration contacts, spare high inputs and internal inputs
	isio_sync #(.WIDTH(`ISIO_CAL_W)) u_cal_sync (
		.mclk(mclk),
		.nrst(nrst),
		.pin_in(cal_request_n),
		.level_out(cal_lvl)
	);

	isio_sync #(.WIDTH(`ISIO_CAL_W)) u_spare_sync (
		.mclk(mclk),
		.nrst(nrst),
		.pin_in(spare_in_high),
		.level_out(spare_lvl)
	);

	isio_sync #(.WIDTH(`ISIO_DW)) u_int_sync (
		.mclk(mclk),
		.nrst(nrst),
		.pin_in(internal_in),
		.level_out(int_lvl)
	);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Access kind of the current cycle
	always_comb
	begin
		if (reg_wr)
			acc = isio_pkg::ISIO_WRITE;
		else if (reg_rd)
			acc = isio_pkg::ISIO_READ;
		else
			acc = isio_pkg::ISIO_IDLE;
	end

	// Write enables per register
	assign wr_cal = (acc == isio_pkg::ISIO_WRITE) && (reg_addr == `ISIO_CAL_PORT);
	assign wr_int = (acc == isio_pkg::ISIO_WRITE) && (reg_addr == `ISIO_INT_PORT);
	assign wr_stat = (acc == isio_pkg::ISIO_WRITE) && (reg_addr == `ISIO_STAT_PORT);
	assign wr_alarm = (acc == isio_pkg::ISIO_WRITE) && (reg_addr == `ISIO_ALARM_PORT);
	assign wr_csel = (acc == isio_pkg::ISIO_WRITE) && (reg_addr == `ISIO_COIL_SEL);
	assign wr_cval = (acc == isio_pkg::ISIO_WRITE) && (reg_addr == `ISIO_COIL_VAL);
	assign wr_evclr = (acc == isio_pkg::ISIO_WRITE) && (reg_addr == `ISIO_EV_CLEAR);
	assign wr_even = (acc == isio_pkg::ISIO_WRITE) && (reg_addr == `ISIO_EV_ENABLE);

	// ----------------------------------------------------------------
	// Output port registers
	// ----------------------------------------------------------------
	// RULE17: hold last written
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			spare_low_q <= `ISIO_SPARE_RST;
			int_out_q <= `ISIO_INT_OUT_RST;
			stat_q <= `ISIO_STAT_RST;
			alarm_q <= `ISIO_ALARM_RST;
		end
		else
		begin
			if (wr_cal)
				spare_low_q <= reg_wdata;
			if (wr_int)
				int_out_q <= reg_wdata;
			// RULE16: status port write
			if (wr_stat)
				stat_q <= reg_wdata;
			// RULE12: alarm port write
			if (wr_alarm)
				alarm_q <= reg_wdata;
		end
	end

	// Remote coil override select and values
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			coil_sel_q <= `ISIO_ZERO_BYTE;
			coil_val_q <= `ISIO_ZERO_BYTE;
		end
		else
		begin
			if (wr_csel)
				coil_sel_q <= reg_wdata;
			if (wr_cval)
				coil_val_q <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Relay drive
	// ----------------------------------------------------------------
	// Local relay value, then the coil override
	always_comb
	begin
		relay_d = alarm_q;
		// RULE7: forced low on any alarm
		relay_d[`ISIO_HEALTH_BIT] = alarm_q[`ISIO_HEALTH_BIT] & ~stat_q[`ISIO_SYS_FLAG_BIT];
		// RULE10: mirrors upper range flag
		relay_d[`ISIO_RANGE_BIT] = ~stat_q[`ISIO_RANGE_FLAG_BIT];
		// RULE11: coil selects relay value
		relay_d = (relay_d & ~coil_sel_q) | (coil_val_q & coil_sel_q);
	end

	// Relay pins come from flip-flops
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			relay_q <= `ISIO_ALARM_RST;
		else
			relay_q <= relay_d;
	end

	// RULE8: limit one relay
	assign limit_one_alarm = relay_q[`ISIO_LIM1_BIT];
	// RULE9: limit two relay
	assign limit_two_alarm = relay_q[`ISIO_LIM2_BIT];
	assign health_alarm_relay = relay_q[`ISIO_HEALTH_BIT];
	assign upper_range_relay = relay_q[`ISIO_RANGE_BIT];
	assign spare_out_high = alarm_q[3:0];
	assign spare_out_low = spare_low_q;

	// RULE13: any alarm flag
	assign system_health_flag = stat_q[`ISIO_SYS_FLAG_BIT];
	// RULE14: reading valid flag
	assign reading_valid_flag = stat_q[`ISIO_VALID_FLAG_BIT];
	// RULE15: range flag
	assign upper_range_flag = stat_q[`ISIO_RANGE_FLAG_BIT];

	// RULE1: peripheral bus reset
	assign periph_bus_reset = int_out_q[`ISIO_PERIPH_RST_BIT];
	assign bus_driver_hw_reset_n = int_out_q[`ISIO_DRV_RST_BIT];

	// ----------------------------------------------------------------
	// Calibration request events and interrupt
	// ----------------------------------------------------------------
	// Previous synchronised request levels
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			cal_prev_q <= `ISIO_CAL_IDLE;
		else
			cal_prev_q <= cal_lvl;
	end

	// RULE5: low while mode wanted
	always_comb
	begin
		ev_set = `ISIO_ZERO_EV;
		// RULE2: zero calibration entry
		ev_set[`ISIO_ZERO_BIT] = cal_prev_q[`ISIO_ZERO_BIT] & ~cal_lvl[`ISIO_ZERO_BIT];
		// RULE3: low span entry
		ev_set[`ISIO_LOW_SPAN_BIT] = cal_prev_q[`ISIO_LOW_SPAN_BIT]
			& ~cal_lvl[`ISIO_LOW_SPAN_BIT];
		// RULE4: span entry
		ev_set[`ISIO_SPAN_BIT] = cal_prev_q[`ISIO_SPAN_BIT] & ~cal_lvl[`ISIO_SPAN_BIT];
		ev_set[`ISIO_EV_RELEASE_BIT] = |(~cal_prev_q[`ISIO_SPAN_BIT:`ISIO_ZERO_BIT]
			& cal_lvl[`ISIO_SPAN_BIT:`ISIO_ZERO_BIT]);
	end

	assign ev_clr = wr_evclr ? reg_wdata[`ISIO_EV_W-1:0] : `ISIO_ZERO_EV;

	// Sticky events, set wins over clear
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			ev_q <= `ISIO_ZERO_EV;
		else
			ev_q <= (ev_q & ~ev_clr) | ev_set;
	end

	// Event enable mask
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			ev_en_q <= `ISIO_ZERO_EV;
		else if (wr_even)
			ev_en_q <= reg_wdata[`ISIO_EV_W-1:0];
	end

	assign irq = |(ev_q & ev_en_q);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Read mux, unmapped reads zero
	always_comb
	begin
		rdata_d = `ISIO_ZERO_BYTE;
		if (acc == isio_pkg::ISIO_READ)
		begin
			case (reg_addr)
				// RULE6: request port, top bits one
				`ISIO_CAL_PORT: rdata_d = {`ISIO_TOP_ONES, cal_lvl};
				// RULE18: synchronised levels
				`ISIO_INT_PORT: rdata_d = int_lvl;
				`ISIO_STAT_PORT: rdata_d = stat_q;
				`ISIO_ALARM_PORT: rdata_d = {`ISIO_TOP_ONES, spare_lvl};
				`ISIO_COIL_SEL: rdata_d = coil_sel_q;
				`ISIO_COIL_VAL: rdata_d = coil_val_q;
				`ISIO_EV_STATUS: rdata_d = {4'h0, ev_q};
				`ISIO_EV_ENABLE: rdata_d = {4'h0, ev_en_q};
				default: rdata_d = `ISIO_ZERO_BYTE;
			endcase
		end
	end

	// Read data valid one cycle after strobe
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			rdata_q <= `ISIO_ZERO_BYTE;
		else
			rdata_q <= rdata_d;
	end

	assign reg_rdata = rdata_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// RULE1: reset bit follows write
	a_periph_reset_write: assert property (@(posedge mclk) disable iff (!nrst) // RULE1
		wr_int |=> periph_bus_reset == $past(reg_wdata[`ISIO_PERIPH_RST_BIT]))
		else $error("peripheral reset bit does not follow write");

	// RULE2: zero request raises event
	a_zero_cal_event: assert property (@(posedge mclk) disable iff (!nrst) // RULE2
		$fell(cal_lvl[`ISIO_ZERO_BIT]) |=> ev_q[`ISIO_ZERO_BIT])
		else $error("zero request did not set event");

	// RULE4: span request raises event
	a_span_cal_event: assert property (@(posedge mclk) disable iff (!nrst) // RULE4
		$fell(cal_lvl[`ISIO_SPAN_BIT]) |=> ev_q[`ISIO_SPAN_BIT])
		else $error("span request did not set event");

	// RULE6: request port read
	a_cal_port_read: assert property (@(posedge mclk) disable iff (!nrst) // RULE6
		(reg_rd && reg_addr == `ISIO_CAL_PORT)
		|=> reg_rdata == {`ISIO_TOP_ONES, $past(cal_lvl)})
		else $error("request port read mismatch");

	// RULE7: health relay low on alarm
	a_health_on_alarm: assert property (@(posedge mclk) disable iff (!nrst) // RULE7
		(stat_q[`ISIO_SYS_FLAG_BIT] && !coil_sel_q[`ISIO_HEALTH_BIT])
		|=> !health_alarm_relay)
		else $error("health relay high during alarm");

	// RULE10: range relay mirrors flag
	a_range_mirror: assert property (@(posedge mclk) disable iff (!nrst) // RULE10
		!coil_sel_q[`ISIO_RANGE_BIT] |=> upper_range_relay == !$past(upper_range_flag))
		else $error("range relay does not mirror flag");

	// RULE11: coil override
	a_coil_override: assert property (@(posedge mclk) disable iff (!nrst) // RULE11
		coil_sel_q[`ISIO_LIM1_BIT] |=> limit_one_alarm == $past(coil_val_q[`ISIO_LIM1_BIT]))
		else $error("coil override not applied");

	// RULE17: status holds without write
	a_status_hold: assert property (@(posedge mclk) disable iff (!nrst) // RULE17
		!wr_stat |=> $stable(stat_q))
		else $error("status port changed without write");

	// RULE18: internal port read
	a_int_port_read: assert property (@(posedge mclk) disable iff (!nrst) // RULE18
		(reg_rd && reg_addr == `ISIO_INT_PORT) |=> reg_rdata == $past(int_lvl))
		else $error("internal port read mismatch");

	// Interrupt high while the zero event is pending and enabled
	a_irq_level: assert property (@(posedge mclk) disable iff (!nrst)
		(ev_q[`ISIO_ZERO_BIT] && ev_en_q[`ISIO_ZERO_BIT]) |-> irq)
		else $error("irq low with enabled event");

	// Main scenarios
	c_zero_request: cover property (@(posedge mclk) disable iff (!nrst)
		$fell(cal_lvl[`ISIO_ZERO_BIT]) ##[1:8] irq);
	c_coil_drive: cover property (@(posedge mclk) disable iff (!nrst)
		wr_csel ##[1:2] wr_cval);
	c_periph_reset: cover property (@(posedge mclk) disable iff (!nrst)
		periph_bus_reset ##1 !periph_bus_reset);
endmodule

// >>> verif/isio_field_model.sv
/*
 Far-side model: calibration contact closures and field input levels.
 Assumes the bench sets want_cal and aux_level just after a clock edge.
*/
`timescale 1ns/1ps

module isio_field_model (
	input wire logic [2:0] want_cal,
	input wire logic [7:0] aux_level,
	output logic [5:0] cal_request_n,
	output logic [5:0] spare_in_high,
	output logic [7:0] internal_in
);
	// ----------------------------------------------------------------
	// Contacts
	// ----------------------------------------------------------------
	// contacts active low
	// Closed contact pulls low for as long as wanted, open ones sit at the pull-up
	assign cal_request_n = {3'h7, ~want_cal};
	// Spare and internal lines follow the bench level
	assign spare_in_high = aux_level[5:0];
	assign internal_in = aux_level;
endmodule

// >>> verif/isio_top_tb.sv
/*
 Self-checking bench for the instrument status I/O ports.
 Assumes isio_regs.svh on the include path and the field model beside it.
*/
`timescale 1ns/1ps
`include "isio_regs.svh"

module isio_top_tb;
	logic mclk, nrst, reg_wr, reg_rd;
	logic [9:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, spare_out_low, aux_level, internal_in, rd;
	logic [3:0] spare_out_high;
	logic [2:0] want_cal;
	logic [5:0] cal_request_n, spare_in_high;
	logic periph_bus_reset, bus_driver_hw_reset_n, system_health_flag, reading_valid_flag;
	logic upper_range_flag, health_alarm_relay, limit_one_alarm, limit_two_alarm;
	logic upper_range_relay, irq;
	int mismatches, num_checks;

	isio_field_model isio_field_model_inst (.want_cal(want_cal), .aux_level(aux_level),
		.cal_request_n(cal_request_n), .spare_in_high(spare_in_high),
		.internal_in(internal_in));

	isio_top isio_top_inst (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cal_request_n(cal_request_n), .spare_in_high(spare_in_high),
		.internal_in(internal_in), .spare_out_low(spare_out_low),
		.spare_out_high(spare_out_high), .periph_bus_reset(periph_bus_reset),
		.bus_driver_hw_reset_n(bus_driver_hw_reset_n),
		.system_health_flag(system_health_flag), .reading_valid_flag(reading_valid_flag),
		.upper_range_flag(upper_range_flag), .health_alarm_relay(health_alarm_relay),
		.limit_one_alarm(limit_one_alarm), .limit_two_alarm(limit_two_alarm),
		.upper_range_relay(upper_range_relay), .irq(irq));

	// ----------------------------------------------------------------
	// Clock and helpers
	// ----------------------------------------------------------------
	// 200 MHz clock
	initial
	begin
		mclk = 1'h0;
		forever #2.5 mclk = ~mclk;
	end

	// Verdict and end of run
	task automatic stop_test;
		$display("Checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Compare and count
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// One-cycle write strobe
	task automatic bus_wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask

	// Read strobe, data taken in the following cycle
	task automatic bus_rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1;
		d = reg_rdata;
	endtask

	function automatic logic [7:0] relays();
		return {4'h0, upper_range_relay, limit_two_alarm, limit_one_alarm, health_alarm_relay};
	endfunction

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Reset state and peripheral reset bits, input readback
	task automatic t_internal;
		check({6'h0, periph_bus_reset, bus_driver_hw_reset_n}, 8'h01);
		bus_rd(`ISIO_STAT_PORT, rd);
		check(rd, 8'h00);
		bus_wr(`ISIO_INT_PORT, 8'h40);
		cycles(1);
		check({6'h0, periph_bus_reset, bus_driver_hw_reset_n}, 8'h02);
		bus_wr(`ISIO_INT_PORT, 8'h80);
		cycles(1);
		check({6'h0, periph_bus_reset, bus_driver_hw_reset_n}, 8'h01);
		@(posedge mclk);
		aux_level <= 8'h5a;
		cycles(6);
		bus_rd(`ISIO_INT_PORT, rd);
		check(rd, 8'h5a);
		bus_rd(`ISIO_ALARM_PORT, rd);
		check(rd, 8'hda);
		bus_rd(10'h3ff, rd);
		check(rd, 8'h00);
	endtask

	// Each calibration contact, event, interrupt and release
	task automatic t_cal;
		int n;
		bus_wr(`ISIO_EV_ENABLE, 8'h0f);
		for (int i = 0; i < 3; i++)
		begin
			want_cal <= 3'(1 << i);
			for (n = 0; n < 12 && irq !== 1'h1; n++)
				@(posedge mclk);
			#1;
			check({7'h0, irq}, 8'h01);
			bus_rd(`ISIO_CAL_PORT, rd);
			check(rd, 8'hff & ~(8'h01 << i));
			bus_rd(`ISIO_EV_STATUS, rd);
			check(rd & 8'h0f, 8'h01 << i);
			bus_wr(`ISIO_EV_CLEAR, 8'h0f);
			want_cal <= 3'h0;
			cycles(8);
			bus_rd(`ISIO_EV_STATUS, rd);
			check(rd & 8'h0f, 8'h08);
			bus_wr(`ISIO_EV_CLEAR, 8'h0f);
			cycles(2);
			check({7'h0, irq}, 8'h00);
		end
		// Masked request keeps the line quiet
		bus_wr(`ISIO_EV_ENABLE, 8'h00);
		want_cal <= 3'h1;
		cycles(8);
		check({7'h0, irq}, 8'h00);
		bus_rd(`ISIO_EV_STATUS, rd);
		check(rd & 8'h0f, 8'h01);
		@(posedge mclk);
		want_cal <= 3'h0;
		cycles(8);
		bus_wr(`ISIO_EV_CLEAR, 8'h0f);
	endtask

	// Status flags against alarm relays, spare outputs
	task automatic t_status;
		logic [7:0] s;
		logic [7:0] a;
		logic [7:0] stat_tab [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h07};
		for (int i = 0; i < 5; i++)
		begin
			for (int j = 0; j < 2; j++)
			begin
				s = stat_tab[i];
				a = j ? 8'h0a : 8'hf5;
				bus_wr(`ISIO_STAT_PORT, s);
				bus_wr(`ISIO_ALARM_PORT, a);
				cycles(2);
				check({5'h0, upper_range_flag, reading_valid_flag, system_health_flag},
					s);
				check(relays(), {4'h0, ~s[2], a[6], a[5], a[4] & ~s[0]});
				check({4'h0, spare_out_high}, {4'h0, a[3:0]});
				bus_rd(`ISIO_STAT_PORT, rd);
				check(rd, s);
			end
		end
		bus_wr(`ISIO_CAL_PORT, 8'ha5);
		cycles(1);
		check(spare_out_low, 8'ha5);
	endtask

	// Remote coil override of every relay bit
	task automatic t_coil;
		bus_wr(`ISIO_STAT_PORT, 8'h00);
		bus_wr(`ISIO_ALARM_PORT, 8'h00);
		bus_wr(`ISIO_COIL_SEL, 8'hff);
		bus_wr(`ISIO_COIL_VAL, 8'hff);
		cycles(2);
		check(relays(), 8'h0f);
		bus_wr(`ISIO_COIL_VAL, 8'h00);
		cycles(2);
		check(relays(), 8'h00);
		bus_wr(`ISIO_COIL_SEL, 8'h00);
		cycles(2);
		check(relays(), 8'h08);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		nrst = 1'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 10'h000;
		reg_wdata = 8'h00;
		want_cal = 3'h0;
		aux_level = 8'hff;
		mismatches = 0;
		num_checks = 0;
		repeat (12) @(posedge mclk);
		nrst <= 1'h1;
		cycles(2);
		t_internal();
		t_cal();
		t_status();
		t_coil();
		stop_test();
	end

	// Cut a hang short
	initial
	begin
		#100us;
		mismatches++;
		stop_test();
	end
endmodule
